// file: hw/crank_cond_pkg.sv
// shared constants and types for the crank sensor conditioner control
package crank_cond_pkg;

  // register indices within each register space
  localparam logic [3:0] RUN_IDX      = 4'hb;
  localparam logic [3:0] AUTO_IDX     = 4'hc;
  localparam logic [3:0] MISC_IDX     = 4'hd;
  localparam logic [3:0] CRANK_IDX    = 4'hd;
  localparam logic [3:0] STAT_IDX     = 4'hb;

  // values after reset
  localparam logic [7:0] RUN_RST      = 8'h53;
  localparam logic [7:0] AUTO_RST     = 8'h21;
  localparam logic [7:0] MISC_RST     = 8'h00;
  localparam logic [7:0] CRANK_RST    = 8'h00;
  localparam logic [3:0] PEAK_RST     = 4'h0;

  // status field positions
  localparam int         PEAK_LSB     = 4;
  localparam int         HI_CLAMP_BIT = 2;
  localparam int         LO_CLAMP_BIT = 1;

  // ladder top and decay interval bias
  localparam logic [3:0] THR_MAX      = 4'hf;
  localparam logic [4:0] MANT_BIAS    = 5'h10;

  // filter shares of the last pulse period: 1/128 and 1/32 per code step
  localparam int         GLITCH_SHIFT = 7;
  localparam int         BLANK_SHIFT  = 5;
  localparam int         PERIOD_W     = 20;
  localparam int         SYNC_W       = 20;

  typedef enum logic [1:0] {SPACE_CFG, SPACE_CTL, SPACE_STAT} reg_space_t;

  // miscellaneous configuration, bit 7 first
  typedef struct packed {
    logic auto_mode;
    logic conditioner_off;
    logic spare;
    logic low_ref;
    logic edge_filter_enable;
    logic single_ended_select;
    logic invert;
    logic mid_reference_detach;
  } misc_t;

  typedef struct packed {
    logic [3:0] thr;
    logic [3:0] blank;
  } param_t;

  typedef struct packed {
    logic [3:0] mant;
    logic [3:0] expo;
  } auto_t;

endpackage

// file: hw/sync2.sv
// two-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ns
module sync2 import crank_cond_pkg::*;
#(
  parameter int W = SYNC_W
)
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      q_sync <= '0;
    end
    else
    begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule // sync2

// file: hw/thr_decay.sv
// automatic mode threshold decay stepper
`timescale 1ns/1ns
module thr_decay import crank_cond_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       zc_load,
  input  wire auto_t      timing,
  input  wire logic [3:0] floor_code,
  // result
  output logic      [3:0] code_r
);

  logic [PERIOD_W-1:0] tick_cnt_r;
  logic [PERIOD_W-1:0] interval;
  logic                tick;

  // interval is (16 + mantissa) shifted by exponent, in clocks; 31 << 15 still fits the counter
  assign interval = (PERIOD_W'(MANT_BIAS) + PERIOD_W'(timing.mant)) << timing.expo;
  // counter runs 0 .. interval-1, so one step lasts exactly interval clocks
  assign tick     = (tick_cnt_r >= interval - PERIOD_W'(1));

  // interval counter restarts at each zero crossing and each step
  always_ff @(posedge clk)
  begin
    if (!rst_n || zc_load || tick)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  // jump to ceiling, then walk down to the chosen level
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      code_r <= THR_MAX;
    else if (zc_load)
      code_r <= THR_MAX;
    else if (code_r < floor_code)
      code_r <= floor_code;
    else if (tick && code_r > floor_code)
      code_r <= code_r - 1'b1;
  end

  a_decay_step : assert property (@(posedge clk) disable iff (!rst_n)
    (tick && !zc_load && code_r > floor_code) |=> code_r == $past(code_r) - 4'h1)
    else $error("decay step missed");

endmodule // thr_decay

// file: hw/crank_sensor_conditioner_ctrl.sv
// control and status logic of the crank sensor input conditioner
// Behaviour
// - misc bit 7 picks manual (0) or automatic (1) threshold selection.
// - manual mode holds threshold at the chosen (cranking, or running if cranking is zero) parameter code.
// - automatic mode jumps threshold to the top code at each zero crossing.
// - threshold then decays to the chosen code, timed by automatic parameters.
// - conditioner-off bit shuts the conditioner; reset value keeps it active.
// - pulse reference 0 times high pulses, 1 times low pulses.
// - enabled edge filters reject edges shorter than about 1% of period.
// - misc bit 3 enables edge filters; resets to 0, disabled.
// - single-ended bit grounds negative input; default differential.
// - invert bit swaps positive and negative inputs.
// - detach bit disconnects internal mid reference; default connected.
// - positive peak digitised into status bits 7 to 4.
// - peak code follows the sixteen step threshold ladder.
// - peak field holds last peak; zero after power-on, soft reset or a lobe that passes no ladder step above 0.
// - two clamp flags show high and low clamp reached.
// - all-zero cranking register selects running register values.
// - parameter bits 7-4 are threshold code, 3-0 blanking code.
`timescale 1ns/1ns
module crank_sensor_conditioner_ctrl import crank_cond_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       soft_reset,
  // register access
  input  wire logic       reg_wr_en,
  input  wire reg_space_t reg_space,
  input  wire logic [3:0] reg_idx,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // analog front end comparators
  input  wire logic       sensor_sign_raw,
  input  wire logic       thr_cmp_raw,
  input  wire logic [15:0] peak_ladder_raw,
  input  wire logic       high_clamp_raw,
  input  wire logic       low_clamp_raw,
  // analog front end controls
  output logic [3:0]      threshold_code,
  output logic            conditioner_off,
  output logic            single_ended_select,
  output logic            mid_reference_detach,
  output logic            inputs_swapped,
  // conditioned pulse to the host
  output logic            cond_out
);

  param_t  run_r;
  auto_t   auto_r;
  misc_t   misc_r;
  param_t  crank_r;
  param_t  chosen;
  logic    init;
  logic [SYNC_W-1:0] sync_q;
  logic    sign_s;
  logic    thr_s;
  logic [15:0] ladder_s;
  logic    hi_clamp_s;
  logic    lo_clamp_s;
  logic    sign_d_r;
  logic    zc_evt;
  logic [3:0] decay_code;
  logic [3:0] thr_code_r;
  logic [3:0] peak_track_r;
  logic [3:0] peak_code_r;
  logic [3:0] ladder_code;
  logic    hi_flag_r;
  logic    lo_flag_r;
  logic    cand;
  logic    filt_r;
  logic    filt_d_r;
  logic [PERIOD_W-1:0] glitch_cnt_r;
  logic [PERIOD_W-1:0] blank_cnt_r;
  logic [PERIOD_W-1:0] per_cnt_r;
  logic [PERIOD_W-1:0] period_r;
  logic [PERIOD_W-1:0] glitch_len;
  logic [PERIOD_W-1:0] blank_len;
  logic    pulse_lvl;
  logic    pulse_d_r;
  logic    out_r;
  logic [7:0] rdata_nxt;

  // power-on and soft reset act alike on all state except the input synchroniser, which only power-on clears
  assign init = !rst_n || soft_reset;

  // configuration and control registers
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      run_r   <= RUN_RST;
      auto_r  <= AUTO_RST;
      misc_r  <= MISC_RST;
      crank_r <= CRANK_RST;
    end
    else if (reg_wr_en)
    begin
      if (reg_space == SPACE_CFG && reg_idx == RUN_IDX)
        run_r <= reg_wdata;
      if (reg_space == SPACE_CFG && reg_idx == AUTO_IDX)
        auto_r <= reg_wdata;
      if (reg_space == SPACE_CFG && reg_idx == MISC_IDX)
        misc_r <= reg_wdata;
      if (reg_space == SPACE_CTL && reg_idx == CRANK_IDX)
        crank_r <= reg_wdata;
    end
  end

  // cranking set wins unless it is all zero
  assign chosen = (crank_r == '0) ? run_r : crank_r;

  // every analog comparator is asynchronous to clk
  sync2 #(.W(SYNC_W)) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .d_async ({sensor_sign_raw, thr_cmp_raw, peak_ladder_raw, high_clamp_raw, low_clamp_raw}),
    .q_sync  (sync_q)
  );

  // swapping inputs inverts the sign seen by all functions
  assign sign_s     = sync_q[19] ^ misc_r.invert;
  assign thr_s      = sync_q[18];
  assign ladder_s   = sync_q[17:2];
  assign hi_clamp_s = misc_r.invert ? sync_q[0] : sync_q[1];
  assign lo_clamp_s = misc_r.invert ? sync_q[1] : sync_q[0];

  // zero crossing ends the positive lobe
  always_ff @(posedge clk)
  begin
    if (init)
      sign_d_r <= 1'b0;
    else
      sign_d_r <= sign_s;
  end
  assign zc_evt = sign_d_r && !sign_s && !misc_r.conditioner_off;

  // automatic decay from the ceiling down to the chosen level
  thr_decay u_decay (
    .clk        (clk),
    .rst_n      (!init),
    .zc_load    (zc_evt),
    .timing     (auto_r),
    .floor_code (chosen.thr),
    .code_r     (decay_code)
  );

  // comparator threshold: fixed in manual mode, decaying in automatic
  always_ff @(posedge clk)
  begin
    if (init)
      thr_code_r <= RUN_RST[7:4];
    else if (misc_r.auto_mode)
      thr_code_r <= decay_code;
    else
      thr_code_r <= chosen.thr;
  end

  // highest ladder step passed, same ladder as the threshold
  always_comb
  begin
    ladder_code = PEAK_RST;
    for (int k = 1; k < 16; k++)
      if (ladder_s[k])
        ladder_code = 4'(k);
  end

  // track the lobe maximum and publish it at the zero crossing
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      peak_track_r <= PEAK_RST;
      peak_code_r  <= PEAK_RST;
    end
    else if (zc_evt)
    begin
      peak_code_r  <= peak_track_r;
      peak_track_r <= PEAK_RST;
    end
    else if (sign_s && ladder_code > peak_track_r)
      peak_track_r <= ladder_code;
  end

  // clamp flags follow the clamp comparators
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      hi_flag_r <= 1'b0;
      lo_flag_r <= 1'b0;
    end
    else
    begin
      hi_flag_r <= hi_clamp_s;
      lo_flag_r <= lo_clamp_s;
    end
  end

  // filter and blanking lengths scale with the last period
  assign glitch_len = period_r >> GLITCH_SHIFT;
  assign blank_len  = PERIOD_W'((period_r >> BLANK_SHIFT) * chosen.blank);
  assign cand       = thr_s && sign_s;

  // accept a new level only once it has held for the filter length
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      filt_r       <= 1'b0;
      glitch_cnt_r <= '0;
    end
    else if (cand == filt_r || blank_cnt_r != '0)
      glitch_cnt_r <= '0;
    else if (!misc_r.edge_filter_enable || glitch_cnt_r >= glitch_len)
    begin
      filt_r       <= cand;
      glitch_cnt_r <= '0;
    end
    else
      glitch_cnt_r <= glitch_cnt_r + 1'b1;
  end

  // one-shot blanking after each accepted edge
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      filt_d_r    <= 1'b0;
      blank_cnt_r <= '0;
    end
    else
    begin
      filt_d_r <= filt_r;
      if (filt_d_r != filt_r)
        blank_cnt_r <= blank_len;
      else if (blank_cnt_r != '0)
        blank_cnt_r <= blank_cnt_r - 1'b1;
    end
  end

  // timed pulse level follows the chosen reference polarity
  assign pulse_lvl = filt_r ^ misc_r.low_ref;

  // period between rising pulse edges; saturates on a stalled wheel
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      pulse_d_r <= 1'b0;
      per_cnt_r <= '0;
      period_r  <= '0;
    end
    else
    begin
      pulse_d_r <= pulse_lvl;
      if (pulse_lvl && !pulse_d_r)
      begin
        period_r  <= per_cnt_r;
        per_cnt_r <= '0;
      end
      else if (per_cnt_r != '1)
        per_cnt_r <= per_cnt_r + 1'b1;
    end
  end

  // conditioned output held low while the conditioner is off
  always_ff @(posedge clk)
  begin
    if (init)
      out_r <= 1'b0;
    else
      out_r <= pulse_lvl && !misc_r.conditioner_off;
  end

  // register readback; unused status bits and unknown indices read zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    unique case (reg_space)
      SPACE_CFG:
      begin
        if (reg_idx == RUN_IDX)
          rdata_nxt = run_r;
        else if (reg_idx == AUTO_IDX)
          rdata_nxt = auto_r;
        else if (reg_idx == MISC_IDX)
          rdata_nxt = misc_r;
      end
      SPACE_CTL:
        if (reg_idx == CRANK_IDX)
          rdata_nxt = crank_r;
      SPACE_STAT:
        if (reg_idx == STAT_IDX)
        begin
          rdata_nxt[PEAK_LSB+:4]   = peak_code_r;
          rdata_nxt[HI_CLAMP_BIT] = hi_flag_r;
          rdata_nxt[LO_CLAMP_BIT] = lo_flag_r;
        end
      default:
        rdata_nxt = 8'h00;
    endcase
  end

  // registered read data, one cycle after the address
  always_ff @(posedge clk)
  begin
    if (init)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= rdata_nxt;
  end

  // front end controls straight from the configuration bits; threshold code from its own register
  assign threshold_code       = thr_code_r;
  assign conditioner_off      = misc_r.conditioner_off;
  assign single_ended_select  = misc_r.single_ended_select;
  assign mid_reference_detach = misc_r.mid_reference_detach;
  assign inputs_swapped       = misc_r.invert;
  assign cond_out             = out_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (init);

  sequence s_crossing;
    misc_r.auto_mode && zc_evt;
  endsequence

  a_manual_hold : assert property (
    !misc_r.auto_mode ##1 !misc_r.auto_mode && $stable(chosen) |=> thr_code_r == $past(chosen.thr))
    else $error("manual threshold wrong");
  a_auto_jump : assert property (
    s_crossing ##1 misc_r.auto_mode |=> thr_code_r == THR_MAX)
    else $error("no jump to ceiling");
  a_decay_floor : assert property (
    misc_r.auto_mode [*3] ##0 $stable(chosen) [*3] |-> thr_code_r >= chosen.thr)
    else $error("threshold under chosen level");
  a_crank_pick : assert property (
    crank_r != '0 |-> chosen == crank_r)
    else $error("cranking set not used");
  a_off_quiet : assert property (
    $past(misc_r.conditioner_off) |-> !cond_out)
    else $error("output while off");
  a_peak_hold : assert property (
    !zc_evt && !soft_reset |=> $stable(peak_code_r))
    else $error("peak changed without crossing");
  a_peak_take : assert property (
    zc_evt |=> peak_code_r == $past(peak_track_r))
    else $error("peak not captured");
  a_clamp_flags : assert property (
    ##1 hi_flag_r == $past(hi_clamp_s) && lo_flag_r == $past(lo_clamp_s))
    else $error("clamp flag mismatch");
  a_filter_off : assert property (
    !misc_r.edge_filter_enable && blank_cnt_r == '0 && cand != filt_r |=> filt_r == $past(cand))
    else $error("unfiltered edge delayed");

endmodule // crank_sensor_conditioner_ctrl

// file: verification/crank_sensor_model.sv
// behavioural crank sensor with its analog comparator front end
`timescale 1ns/1ns
module crank_sensor_model
(
  // clock
  input  wire logic        clk,
  // comparator levels towards the conditioner
  output logic             sign_raw,
  output logic             thr_raw,
  output logic [15:0]      ladder_raw,
  output logic             hi_clamp_raw,
  output logic             lo_clamp_raw
);
  // quiet sensor at time zero
  initial
  begin
    sign_raw     = 1'b0;
    thr_raw      = 1'b0;
    ladder_raw   = 16'h0000;
    hi_clamp_raw = 1'b0;
    lo_clamp_raw = 1'b0;
  end

  // one positive lobe peaking at ladder step pk, ended by a zero crossing;
  // hold sets a prompt or a slow lobe
  task automatic lobe(input logic [3:0] pk, input int hold);
    @(negedge clk);
    sign_raw   = 1'b1;
    thr_raw    = 1'b1;
    ladder_raw = 16'hffff >> (4'hf - pk);
    repeat (hold) @(negedge clk);
    sign_raw   = 1'b0;
    thr_raw    = 1'b0;
    ladder_raw = 16'h0000;
  endtask

  // clamp comparators change at a falling edge only
  task automatic clamp(input logic hi, input logic lo);
    @(negedge clk);
    hi_clamp_raw = hi;
    lo_clamp_raw = lo;
  endtask
endmodule // crank_sensor_model

// file: verification/crank_sensor_conditioner_ctrl_tb_top.sv
// self-checking testbench of the crank sensor conditioner control
`timescale 1ns/1ns
module crank_sensor_conditioner_ctrl_tb_top import crank_cond_pkg::*;;
  logic        clk;
  logic        rst_n;
  logic        soft_reset;
  logic        reg_wr_en;
  reg_space_t  reg_space;
  logic [3:0]  reg_idx;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        sign_raw;
  logic        thr_raw;
  logic [15:0] ladder_raw;
  logic        hi_raw;
  logic        lo_raw;
  logic [3:0]  threshold_code;
  logic        conditioner_off;
  logic        single_ended_select;
  logic        mid_reference_detach;
  logic        inputs_swapped;
  logic        cond_out;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;
  int          rises = 0;
  logic        cond_d = 1'b0;

  crank_sensor_conditioner_ctrl uut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .reg_wr_en(reg_wr_en), .reg_space(reg_space), .reg_idx(reg_idx), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sensor_sign_raw(sign_raw), .thr_cmp_raw(thr_raw),
    .peak_ladder_raw(ladder_raw), .high_clamp_raw(hi_raw), .low_clamp_raw(lo_raw),
    .threshold_code(threshold_code), .conditioner_off(conditioner_off),
    .single_ended_select(single_ended_select), .mid_reference_detach(mid_reference_detach),
    .inputs_swapped(inputs_swapped), .cond_out(cond_out));

  crank_sensor_model fe (.clk(clk), .sign_raw(sign_raw), .thr_raw(thr_raw),
    .ladder_raw(ladder_raw), .hi_clamp_raw(hi_raw), .lo_clamp_raw(lo_raw));

  // 25 MHz core clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // count accepted output pulses; sampled away from the launching edge
  always @(negedge clk)
  begin
    cond_d <= cond_out;
    if (cond_out === 1'b1 && cond_d === 1'b0)
      rises <= rises + 1;
  end

  // hang guard: the whole sequence needs well under 2000 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // one-cycle write strobe, then one idle cycle so that two calls never drive the strobe in one step
  task automatic wr(input reg_space_t s, input logic [3:0] i, input logic [7:0] d);
    reg_wr_en = 1'b1;
    reg_space = s;
    reg_idx   = i;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    @(negedge clk);
  endtask

  // read data is registered, so it is sampled one falling edge later
  task automatic rd(input reg_space_t s, input logic [3:0] i, input logic [7:0] e);
    reg_space = s;
    reg_idx   = i;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask

  initial
  begin
    rst_n      = 1'b0;
    soft_reset = 1'b0;
    reg_wr_en  = 1'b0;
    reg_space  = SPACE_CFG;
    reg_idx    = 4'h0;
    reg_wdata  = 8'h00;
    cyc(6);
    rst_n = 1'b1;
    cyc(1);
    chk(threshold_code, 4'h5);
    rd(SPACE_CFG, RUN_IDX, 8'h53);
    rd(SPACE_CFG, AUTO_IDX, 8'h21);
    rd(SPACE_CFG, MISC_IDX, 8'h00);
    rd(SPACE_CTL, CRANK_IDX, 8'h00);
    rd(SPACE_STAT, STAT_IDX, 8'h00);
    rd(SPACE_CFG, 4'h0, 8'h00);
    // cranking code wins while non-zero, running code once it is cleared
    wr(SPACE_CTL, CRANK_IDX, 8'h90);
    wr(SPACE_CFG, RUN_IDX, 8'h73);
    cyc(2);
    chk(threshold_code, 4'h9);
    wr(SPACE_CTL, CRANK_IDX, 8'h00);
    cyc(2);
    chk(threshold_code, 4'h7);
    // front end control bits
    wr(SPACE_CFG, MISC_IDX, 8'h47);
    cyc(1);
    chk({conditioner_off, single_ended_select, inputs_swapped, mid_reference_detach}, 4'hf);
    rd(SPACE_CFG, MISC_IDX, 8'h47);
    wr(SPACE_CFG, MISC_IDX, 8'h08);
    rd(SPACE_CFG, MISC_IDX, 8'h08);
    wr(SPACE_CFG, MISC_IDX, 8'h10);
    cyc(4);
    chk(cond_out, 1'b1);
    wr(SPACE_CFG, MISC_IDX, 8'h50);
    cyc(4);
    chk(cond_out, 1'b0);
    // hall-ready setting: both grounding and detach bits cleared
    wr(SPACE_CFG, MISC_IDX, 8'h00);
    wr(SPACE_STAT, STAT_IDX, 8'hff);
    rd(SPACE_STAT, STAT_IDX, 8'h00);
    // host reads the peak after each crossing
    fe.lobe(4'h7, 8);
    cyc(6);
    rd(SPACE_STAT, STAT_IDX, 8'h70);
    chk(threshold_code, 4'h7);
    fe.lobe(4'h3, 3);
    cyc(6);
    rd(SPACE_STAT, STAT_IDX, 8'h30);
    // a clamp flag hints that running values may be taken
    fe.clamp(1'b1, 1'b0);
    cyc(5);
    rd(SPACE_STAT, STAT_IDX, 8'h34);
    fe.clamp(1'b0, 1'b1);
    cyc(5);
    rd(SPACE_STAT, STAT_IDX, 8'h32);
    fe.clamp(1'b0, 1'b0);
    cyc(5);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    rd(SPACE_STAT, STAT_IDX, 8'h00);
    rd(SPACE_CFG, RUN_IDX, 8'h53);
    // host chose mantissa 0, exponent 0 from peak and tau: 16 clocks a step
    wr(SPACE_CTL, CRANK_IDX, 8'h40);
    wr(SPACE_CFG, AUTO_IDX, 8'h00);
    wr(SPACE_CFG, MISC_IDX, 8'h80);
    cyc(400);
    chk(threshold_code, 4'h4);
    fe.lobe(4'hf, 8);
    n = 0;
    while (threshold_code !== 4'hf && n < 20)
    begin
      cyc(1);
      n++;
    end
    chk(threshold_code, 4'hf);
    n = 0;
    while (threshold_code !== 4'h4 && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk(threshold_code, 4'h4);
    chk(n >= 168 && n <= 184, 1'b1);
    rd(SPACE_STAT, STAT_IDX, 8'hf0);
    // last period is about 400 clocks, so the edge filter length is 3 and it needs 4 clocks of stable input
    wr(SPACE_CFG, MISC_IDX, 8'h08);
    n = rises;
    fe.lobe(4'h2, 2);
    cyc(6);
    chk(16'(rises - n), 16'h0000);
    fe.lobe(4'h2, 8);
    cyc(6);
    chk(16'(rises - n), 16'h0001);
    rd(SPACE_STAT, STAT_IDX, 8'h20);
    report_and_stop();
  end
endmodule // crank_sensor_conditioner_ctrl_tb_top
